// >>> verilog/msp_pkg.sv
// Purpose: shared constants for the multiprotocol serial port block
// Assumes: APB slave, 32-bit data, byte addresses, one clock
// Notes:   register offsets, field positions, reset values and state enums

package msp_pkg;

	// register byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_MODE = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_TXD  = 8'h0C;
	localparam logic [7:0] A_RXD  = 8'h10;
	localparam logic [7:0] A_BRG  = 8'h14;
	localparam logic [7:0] A_SYNC = 8'h18;
	localparam logic [7:0] A_MCTL = 8'h1C;

	// control register bits
	localparam int C_DTR    = 0;
	localparam int C_RTS    = 1;
	localparam int C_TXEN   = 2;
	localparam int C_RXEN   = 3;
	localparam int C_AUTO   = 4;
	localparam int C_DTRREQ = 5;
	localparam int C_REQ    = 6;
	localparam int C_REQRX  = 7;

	// mode register fields (low bit of each)
	localparam int M_SYNC   = 0;
	localparam int M_FACT   = 2;
	localparam int M_XTAL   = 4;
	localparam int M_RXSRC  = 5;
	localparam int M_TXSRC  = 7;
	localparam int M_TRXOUT = 9;
	localparam int M_TRXSEL = 10;
	localparam int M_BRGSRC = 12;

	// master control fields
	localparam int MC_MIE = 0;
	localparam int MC_CMD = 1;

	// reset values; request bit clear means the wait function
	localparam logic [7:0]  CTRL_RST = 8'h00;
	localparam logic [12:0] MODE_RST = 13'h0000;
	localparam logic [15:0] BRG_RST  = 16'h0000;
	localparam logic [7:0]  SYNC_RST = 8'h00;

	// receive and transmit mode codes
	localparam logic [1:0] SM_ASYNC = 2'h0;
	localparam logic [1:0] SM_EXT   = 2'h1;
	localparam logic [1:0] SM_INT   = 2'h2;
	localparam logic [1:0] SM_SDLC  = 2'h3;

	// clock factor minus one for x1, x16, x32, x64
	localparam logic [5:0] FM1_X1  = 6'h00;
	localparam logic [5:0] FM1_X16 = 6'h0F;
	localparam logic [5:0] FM1_X32 = 6'h1F;
	localparam logic [5:0] FM1_X64 = 6'h3F;

	// reset commands in the master control register
	localparam logic [1:0] CMD_RST_B  = 2'h1;
	localparam logic [1:0] CMD_RST_A  = 2'h2;
	localparam logic [1:0] CMD_RST_HW = 2'h3;

	localparam logic [7:0] SDLC_FLAG  = 8'h7E;
	localparam logic [1:0] IACK_WAITS = 2'h2;

	typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} msp_tx_st_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} msp_rx_st_t;

endpackage

// >>> verilog/msp_edge.sv
// Purpose: samples one pin and reports its level and both transitions
// Assumes: pin already synchronous to CLK_I
// Notes:   rise and fall are one-cycle pulses after the sampled change

`timescale 1ns/1ns
`default_nettype none

module msp_edge #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic pin_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);

	typedef struct packed {
		logic cur;
		logic prev;
	} msp_edge_t;

	msp_edge_t s;
	msp_edge_t next_s;

	// shift the sample history by one
	always_comb begin
		next_s.cur = pin_i;
		next_s.prev = s.cur;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '{cur: RST_VAL, prev: RST_VAL};
		end else begin
			s <= next_s;
		end
	end

	assign level_o = s.cur;
	assign rise_o  = s.cur & ~s.prev;
	assign fall_o  = ~s.cur & s.prev;

endmodule // msp_edge

`default_nettype wire

// >>> verilog/msp_port.sv
// Purpose: one multiprotocol serial channel with modem pins, APB registers
// Assumes: all pins synchronous to CLK_I; CLK_I is the system clock
// Notes:   no phase-locked loop; its output selection carries the baud clock
//
// Behaviour
// R1: wait/request pin is open-drain for wait, driven both ways for request.
// R2: wait pulls low while access not ready; request asserts when port ready.
// R3: after reset the wait/request pin performs the wait function.
// R4: async without crystal: sync pin input only updates sync/hunt status.
// R5: far end pulls sync low two receive clocks after last sync bit.
// R6: external sync: assembly starts at receive edge preceding sync low.
// R7: internal sync: sync output active only during the matching clock period.
// R8: SDLC: sync output becomes valid on receipt of a flag.
// R9: receive/transmit clock pin feeds receive, transmit, baud gen or crystal.
// R10: async receive clock is 1, 16, 32 or 64 times the bit rate.
// R11: transmit/receive clock pin is a clock input or a selectable clock output.
// R12: terminal-ready output follows its bit, or serves as DMA request.
// R13: send-request bit set drives the send-request output low.
// R14: async auto enable: cleared send-request releases only after tx empties.
// R15: auto enable: clear-to-send low enables tx, else general input.
// R16: auto enable: carrier detect enables receiver, else general input.
// R17: both edges of clear-to-send and carrier detect can interrupt.
// R18: reset is held at least three system clocks by the outside.
// R19: the serial channel keeps running while the processor is stopped.
// R20: interrupt acknowledge cycles get two automatic wait states.
// R21: channel B software reset command has no effect.
// R22: clocked by the system clock; interrupt drives a shared open-drain line.

`timescale 1ns/1ns
`default_nettype none

module msp_port (
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	input  wire logic        IACK_I,
	input  wire logic        RXD_I,
	output logic             TXD_O,
	input  wire logic        RX_TX_CLK_N_I,
	input  wire logic        TX_RX_CLK_N_I,
	output logic             TX_RX_CLK_N_O,
	output logic             TX_RX_CLK_N_OE,
	input  wire logic        SYNC_N_I,
	output logic             SYNC_N_O,
	output logic             SYNC_N_OE,
	output logic             W_REQ_N_O,
	output logic             W_REQ_N_OE,
	output logic             DTR_REQ_N_O,
	output logic             RTS_N_O,
	input  wire logic        CTS_N_I,
	input  wire logic        CARRIER_DET_N_I,
	output logic             INT_N_O,
	output logic             INT_N_OE
);

	typedef struct packed {
		logic [7:0]           ctrl;
		logic [12:0]          mode;
		logic                 mie;
		logic [15:0]          brg_tc;
		logic [7:0]           sync_chr;
		logic [15:0]          brg_cnt;
		logic                 brg_lvl;
		logic                 tx_full;
		logic [7:0]           tx_hold;
		logic [9:0]           tx_sh;
		logic [3:0]           tx_bits;
		logic [5:0]           tx_ph;
		msp_pkg::msp_tx_st_t  tx_st;
		logic                 txd;
		msp_pkg::msp_rx_st_t  rx_st;
		logic [7:0]           rx_sh;
		logic [3:0]           rx_bits;
		logic [5:0]           rx_ph;
		logic [7:0]           rx_data;
		logic                 rx_full;
		logic                 rx_ferr;
		logic                 hunt;
		logic                 sync_act;
		logic                 cts_edge;
		logic                 dcd_edge;
		logic                 sync_edge;
		logic                 rts_low;
		logic [1:0]           wait_cnt;
		logic                 tx_rx_clock_pin_o;
	} msp_state_t;

	msp_state_t s;
	msp_state_t next_s;

	logic rx_tx_clock_pin_lvl;
	logic rx_tx_clock_pin_rise;
	logic tx_rx_clock_pin_lvl;
	logic tx_rx_clock_pin_rise;
	logic cts_lvl;
	logic cts_rise;
	logic cts_fall;
	logic dcd_lvl;
	logic dcd_rise;
	logic dcd_fall;
	logic sync_lvl;
	logic sync_rise;
	logic sync_fall;

	// pin samplers; idle level of active-low pins is high
	msp_edge #(.RST_VAL(1'b1)) u_rx_tx_clock_pin (.clk_i(CLK_I), .rst_i(RST_I),
		.pin_i(RX_TX_CLK_N_I), .level_o(rx_tx_clock_pin_lvl), .rise_o(rx_tx_clock_pin_rise),
		.fall_o());
	msp_edge #(.RST_VAL(1'b1)) u_tx_rx_clock_pin (.clk_i(CLK_I), .rst_i(RST_I),
		.pin_i(TX_RX_CLK_N_I), .level_o(tx_rx_clock_pin_lvl), .rise_o(tx_rx_clock_pin_rise),
		.fall_o());
	msp_edge #(.RST_VAL(1'b1)) u_cts (.clk_i(CLK_I), .rst_i(RST_I),
		.pin_i(CTS_N_I), .level_o(cts_lvl), .rise_o(cts_rise),
		.fall_o(cts_fall));
	msp_edge #(.RST_VAL(1'b1)) u_dcd (.clk_i(CLK_I), .rst_i(RST_I),
		.pin_i(CARRIER_DET_N_I), .level_o(dcd_lvl), .rise_o(dcd_rise),
		.fall_o(dcd_fall));
	msp_edge #(.RST_VAL(1'b1)) u_sync (.clk_i(CLK_I), .rst_i(RST_I),
		.pin_i(SYNC_N_I), .level_o(sync_lvl), .rise_o(sync_rise),
		.fall_o(sync_fall));

	logic [1:0] smode;
	logic       async_m;
	logic       xtal;
	logic       trx_out;
	logic [5:0] fm1;
	logic       brg_en;
	logic       brg_tick;
	logic       tx_tick;
	logic       rx_tick;
	logic       cts_on;
	logic       dcd_on;
	logic       all_sent;
	logic       wait_m;
	logic       acc;
	logic       stall;
	logic       done;
	logic       mapped;

	// pick one clock tick source: 0 pin one, 1 pin two, else baud gen
	function automatic logic src_tick(input logic [1:0] sel, input logic r1,
		input logic r2, input logic b, input logic out);
		src_tick = (sel == 2'h0) ? r1 : (sel == 2'h1) ? (r2 & ~out) : b;
	endfunction

	assign smode   = s.mode[msp_pkg::M_SYNC +: 2];
	assign async_m = (smode == msp_pkg::SM_ASYNC);
	assign xtal    = s.mode[msp_pkg::M_XTAL];
	assign trx_out = s.mode[msp_pkg::M_TRXOUT];
	assign cts_on  = ~cts_lvl;
	assign dcd_on  = ~dcd_lvl;
	assign all_sent = (s.tx_st == msp_pkg::TX_IDLE) & ~s.tx_full;

	// baud generator may count system clocks or pin edges
	assign brg_en   = s.mode[msp_pkg::M_BRGSRC] ? rx_tx_clock_pin_rise : 1'b1; // R9
	assign brg_tick = brg_en & (s.brg_cnt == 16'h0000);
	assign tx_tick  = src_tick(s.mode[msp_pkg::M_TXSRC +: 2], rx_tx_clock_pin_rise,
		tx_rx_clock_pin_rise, brg_tick, trx_out); // R9 R11
	assign rx_tick  = src_tick(s.mode[msp_pkg::M_RXSRC +: 2], rx_tx_clock_pin_rise,
		tx_rx_clock_pin_rise, brg_tick, trx_out); // R9 R11

	// clock factor, async only; synchronous modes run at x1
	always_comb begin
		unique case (s.mode[msp_pkg::M_FACT +: 2])
			2'h0: fm1 = msp_pkg::FM1_X1;
			2'h1: fm1 = msp_pkg::FM1_X16;
			2'h2: fm1 = msp_pkg::FM1_X32;
			2'h3: fm1 = msp_pkg::FM1_X64;
		endcase
		if (!async_m) begin
			fm1 = msp_pkg::FM1_X1;
		end
	end // R10

	// wait function stalls the bus on data access that is not ready
	assign wait_m = ~s.ctrl[msp_pkg::C_REQ];
	assign acc    = PSEL_I & PENABLE_I;
	assign stall  = wait_m & acc & (
		(PWRITE_I & (PADDR_I == msp_pkg::A_TXD) & s.tx_full) |
		(~PWRITE_I & (PADDR_I == msp_pkg::A_RXD) & ~s.rx_full)); // R2
	assign done   = acc & ~stall;
	assign mapped = (PADDR_I[1:0] == 2'h0) && (PADDR_I <= msp_pkg::A_MCTL);

	// next-state logic; no stop input exists, so nothing here ever halts
	always_comb begin
		next_s = s; // R19

		// a data read clears first, so an arrival later on in here wins
		if (done & ~PWRITE_I & (PADDR_I == msp_pkg::A_RXD)) begin
			next_s.rx_full = 1'b0;
		end

		// baud generator reload and output toggle
		if (brg_en) begin
			if (s.brg_cnt == 16'h0000) begin
				next_s.brg_cnt = s.brg_tc;
				next_s.brg_lvl = ~s.brg_lvl;
			end else begin
				next_s.brg_cnt = s.brg_cnt - 16'h0001;
			end
		end

		// clock output selection; no loop, so the phase slot carries baud
		unique case (s.mode[msp_pkg::M_TRXSEL +: 2])
			2'h0: next_s.tx_rx_clock_pin_o = (s.mode[msp_pkg::M_TXSRC +: 2] == 2'h0) ?
				rx_tx_clock_pin_lvl : s.brg_lvl;
			2'h1: next_s.tx_rx_clock_pin_o = s.brg_lvl;
			2'h2: next_s.tx_rx_clock_pin_o = s.brg_lvl;
			2'h3: next_s.tx_rx_clock_pin_o = rx_tx_clock_pin_lvl;
		endcase // R11

		// transmitter; clear-to-send gates the start under auto enable
		unique case (s.tx_st)
			msp_pkg::TX_IDLE: begin
				if (tx_tick & s.tx_full & s.ctrl[msp_pkg::C_TXEN] &
					(~s.ctrl[msp_pkg::C_AUTO] | cts_on)) begin // R15
					next_s.tx_sh = async_m ? {1'b1, s.tx_hold, 1'b0} :
						{2'b11, s.tx_hold};
					next_s.tx_bits = async_m ? 4'hA : 4'h8;
					next_s.txd = async_m ? 1'b0 : s.tx_hold[0];
					next_s.tx_full = 1'b0;
					next_s.tx_ph = fm1;
					next_s.tx_st = msp_pkg::TX_SHIFT;
				end
			end
			msp_pkg::TX_SHIFT: begin
				if (tx_tick) begin
					if (s.tx_ph != 6'h00) begin
						next_s.tx_ph = s.tx_ph - 6'h01;
					end else begin
						next_s.tx_ph = fm1;
						next_s.tx_bits = s.tx_bits - 4'h1;
						next_s.tx_sh = {1'b1, s.tx_sh[9:1]};
						next_s.txd = s.tx_sh[1];
						if (s.tx_bits == 4'h1) begin
							next_s.txd = 1'b1;
							next_s.tx_st = msp_pkg::TX_IDLE;
						end
					end
				end
			end
		endcase

		// asynchronous receiver, enabled by carrier detect under auto
		if (async_m) begin
			next_s.hunt = ~sync_lvl; // R4
			if (rx_tick & s.ctrl[msp_pkg::C_RXEN] &
				(~s.ctrl[msp_pkg::C_AUTO] | dcd_on)) begin // R16
				unique case (s.rx_st)
					msp_pkg::RX_IDLE: begin
						if (!RXD_I) begin
							next_s.rx_bits = 4'h0;
							next_s.rx_ph = (fm1 == 6'h00) ? 6'h00 :
								{1'b0, fm1[5:1]} - 6'h01;
							next_s.rx_st = (fm1 == 6'h00) ?
								msp_pkg::RX_DATA : msp_pkg::RX_START;
						end
					end
					msp_pkg::RX_START: begin
						if (s.rx_ph != 6'h00) begin
							next_s.rx_ph = s.rx_ph - 6'h01;
						end else begin
							next_s.rx_ph = fm1;
							next_s.rx_st = RXD_I ? msp_pkg::RX_IDLE :
								msp_pkg::RX_DATA;
						end
					end
					msp_pkg::RX_DATA: begin
						if (s.rx_ph != 6'h00) begin
							next_s.rx_ph = s.rx_ph - 6'h01;
						end else begin
							next_s.rx_ph = fm1;
							next_s.rx_sh = {RXD_I, s.rx_sh[7:1]};
							next_s.rx_bits = s.rx_bits + 4'h1;
							if (s.rx_bits == 4'h7) begin
								next_s.rx_st = msp_pkg::RX_STOP;
							end
						end
					end
					msp_pkg::RX_STOP: begin
						if (s.rx_ph != 6'h00) begin
							next_s.rx_ph = s.rx_ph - 6'h01;
						end else begin
							next_s.rx_data = s.rx_sh;
							next_s.rx_full = 1'b1;
							next_s.rx_ferr = ~RXD_I;
							next_s.rx_st = msp_pkg::RX_IDLE;
						end
					end
				endcase // R10
			end
		end else begin
			// external sync: the bit taken at the preceding edge is bit one
			if ((smode == msp_pkg::SM_EXT) & ~xtal & s.hunt & sync_fall) begin
				next_s.hunt = 1'b0;
				next_s.rx_bits = 4'h1; // R6
			end
			if (rx_tick & s.ctrl[msp_pkg::C_RXEN] &
				(~s.ctrl[msp_pkg::C_AUTO] | dcd_on)) begin // R16
				next_s.rx_sh = {RXD_I, s.rx_sh[7:1]};
				// match runs on every bit, regardless of character boundary
				next_s.sync_act =
					((smode == msp_pkg::SM_INT) &
					({RXD_I, s.rx_sh[7:1]} == s.sync_chr)) |
					((smode == msp_pkg::SM_SDLC) &
					({RXD_I, s.rx_sh[7:1]} == msp_pkg::SDLC_FLAG)); // R7 R8
				if (s.hunt) begin
					if (next_s.sync_act) begin
						next_s.hunt = 1'b0;
						next_s.rx_bits = 4'h0;
					end
				end else if (next_s.rx_bits == 4'h7) begin
					next_s.rx_data = {RXD_I, s.rx_sh[7:1]};
					next_s.rx_full = 1'b1;
					next_s.rx_bits = 4'h0;
				end else begin
					next_s.rx_bits = next_s.rx_bits + 4'h1;
				end
			end
		end

		// send-request release waits for an empty transmitter under async auto
		next_s.rts_low = s.ctrl[msp_pkg::C_RTS] | (async_m &
			s.ctrl[msp_pkg::C_AUTO] & s.rts_low & ~all_sent); // R13 R14

		// acknowledge cycle wait states
		if (IACK_I) begin
			next_s.wait_cnt = msp_pkg::IACK_WAITS; // R20
		end else if (s.wait_cnt != 2'h0) begin
			next_s.wait_cnt = s.wait_cnt - 2'h1;
		end

		// register writes; status bits 6 to 9 (edge flags, framing error) are write-one-to-clear
		if (done & PWRITE_I) begin
			unique case (PADDR_I)
				msp_pkg::A_CTRL: next_s.ctrl = PWDATA_I[7:0];
				msp_pkg::A_MODE: begin
					next_s.mode = PWDATA_I[12:0];
					next_s.hunt = 1'b1;
				end
				msp_pkg::A_STAT: begin
					next_s.cts_edge = s.cts_edge & ~PWDATA_I[6];
					next_s.dcd_edge = s.dcd_edge & ~PWDATA_I[7];
					next_s.sync_edge = s.sync_edge & ~PWDATA_I[8];
					next_s.rx_ferr = s.rx_ferr & ~PWDATA_I[9];
				end
				msp_pkg::A_TXD: begin
					if (!s.tx_full) begin
						next_s.tx_hold = PWDATA_I[7:0];
						next_s.tx_full = 1'b1;
					end
				end
				msp_pkg::A_BRG: next_s.brg_tc = PWDATA_I[15:0];
				msp_pkg::A_SYNC: next_s.sync_chr = PWDATA_I[7:0];
				msp_pkg::A_MCTL: begin
					next_s.mie = PWDATA_I[msp_pkg::MC_MIE];
					// only one channel: the channel B command falls through
					if (PWDATA_I[msp_pkg::MC_CMD +: 2] == msp_pkg::CMD_RST_A ||
						PWDATA_I[msp_pkg::MC_CMD +: 2] == msp_pkg::CMD_RST_HW) begin
						next_s.ctrl = msp_pkg::CTRL_RST;
						next_s.mode = msp_pkg::MODE_RST;
						next_s.tx_full = 1'b0;
						next_s.tx_st = msp_pkg::TX_IDLE;
						next_s.txd = 1'b1;
						next_s.rx_st = msp_pkg::RX_IDLE;
						next_s.rx_full = 1'b0;
						next_s.hunt = 1'b1;
					end // R21
				end
				default: ;
			endcase
		end
		// both edges of modem inputs latch; set beats clear
		next_s.cts_edge = next_s.cts_edge | cts_rise | cts_fall; // R17
		next_s.dcd_edge = next_s.dcd_edge | dcd_rise | dcd_fall; // R17
		next_s.sync_edge = next_s.sync_edge |
			((sync_rise | sync_fall) & async_m & ~xtal); // R4
	end

	// outside reset holds at least three clocks; one edge is enough here
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			s <= '0; // R18
			s.ctrl <= msp_pkg::CTRL_RST; // R3
			s.mode <= msp_pkg::MODE_RST;
			s.brg_tc <= msp_pkg::BRG_RST;
			s.sync_chr <= msp_pkg::SYNC_RST;
			s.txd <= 1'b1;
			s.hunt <= 1'b1;
			s.tx_rx_clock_pin_o <= 1'b1;
			s.tx_st <= msp_pkg::TX_IDLE;
			s.rx_st <= msp_pkg::RX_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// register read mux; unmapped addresses answer with an error
	always_comb begin
		PRDATA_O = 32'h0000_0000;
		unique case (PADDR_I)
			msp_pkg::A_CTRL: PRDATA_O = {24'h000000, s.ctrl};
			msp_pkg::A_MODE: PRDATA_O = {19'h00000, s.mode};
			msp_pkg::A_STAT: PRDATA_O = {22'h000000, s.rx_ferr, s.sync_edge,
				s.dcd_edge, s.cts_edge, s.hunt, dcd_on, cts_on, all_sent,
				~s.tx_full, s.rx_full}; // R15 R16
			msp_pkg::A_RXD:  PRDATA_O = {24'h000000, s.rx_data};
			msp_pkg::A_BRG:  PRDATA_O = {16'h0000, s.brg_tc};
			msp_pkg::A_SYNC: PRDATA_O = {24'h000000, s.sync_chr};
			msp_pkg::A_MCTL: PRDATA_O = {31'h00000000, s.mie};
			default:         PRDATA_O = 32'h0000_0000;
		endcase
	end
	assign PREADY_O  = ~stall;
	assign PSLVERR_O = done & ~mapped;

	// wait: open drain, low while stalled or acknowledging; request: push-pull
	assign W_REQ_N_OE = wait_m ? (stall | (s.wait_cnt != 2'h0)) : 1'b1; // R1
	assign W_REQ_N_O  = wait_m ? 1'b0 : ~(s.ctrl[msp_pkg::C_REQRX] ?
		s.rx_full : ~s.tx_full); // R2

	// modem and line outputs
	assign DTR_REQ_N_O = s.ctrl[msp_pkg::C_DTRREQ] ?
		~(~s.tx_full & s.ctrl[msp_pkg::C_TXEN]) :
		~s.ctrl[msp_pkg::C_DTR]; // R12
	assign RTS_N_O = ~s.rts_low; // R13
	assign TXD_O   = s.txd;

	// sync pin drives only in internal sync and flag modes, never with crystal
	assign SYNC_N_OE = ((smode == msp_pkg::SM_INT) |
		(smode == msp_pkg::SM_SDLC)) & ~xtal; // R7 R8
	assign SYNC_N_O  = ~s.sync_act;

	assign TX_RX_CLK_N_OE = trx_out; // R11
	assign TX_RX_CLK_N_O  = s.tx_rx_clock_pin_o;

	// shared interrupt line is only ever pulled low
	assign INT_N_O  = 1'b0;
	assign INT_N_OE = s.mie & (s.cts_edge | s.dcd_edge | s.sync_edge); // R22

endmodule // msp_port

`default_nettype wire

// >>> tb/msp_checker.sv
// Purpose: port-level checks for the serial port block
// Assumes: bound to msp_port; wait function after reset
// Notes:   sees only top ports, so mode-bound rules are tied to writes
`timescale 1ns/1ns
`default_nettype none
module msp_checker (
	input wire logic        CLK_I,
	input wire logic        RST_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PWRITE_I,
	input wire logic [7:0]  PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic        PREADY_O,
	input wire logic        IACK_I,
	input wire logic        W_REQ_N_O,
	input wire logic        W_REQ_N_OE,
	input wire logic        RTS_N_O,
	input wire logic        DTR_REQ_N_O,
	input wire logic        SYNC_N_OE,
	input wire logic        INT_N_OE
);
	// writes taken at this edge, to control and to mode-changing places
	wire logic wt = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
	wire logic wc = wt && PADDR_I == msp_pkg::A_CTRL;
	wire logic wm = wt && (PADDR_I == msp_pkg::A_MODE
		|| PADDR_I == msp_pkg::A_MCTL);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (RST_I);

	a_reset_pins: assert property (disable iff (1'b0)
		RST_I |-> RTS_N_O && DTR_REQ_N_O && !W_REQ_N_OE && !SYNC_N_OE
		&& !INT_N_OE) else $error("pins active during reset");
	a_wait_after: assert property ($fell(RST_I) |-> !W_REQ_N_OE)
		else $error("wait pin driven after reset");
	a_stall_pulls: assert property (
		PSEL_I && PENABLE_I && !PREADY_O |-> W_REQ_N_OE && !W_REQ_N_O)
		else $error("stall without wait pulled low");
	a_ctrl_ready: assert property (
		PSEL_I && PENABLE_I && PADDR_I == msp_pkg::A_CTRL |-> PREADY_O)
		else $error("control access stalled");
	a_iack_waits: assert property (IACK_I |=> W_REQ_N_OE [*2])
		else $error("acknowledge not stretched two cycles");
	a_rts_sets: assert property (
		wc && PWDATA_I[msp_pkg::C_RTS] |-> ##2 !RTS_N_O)
		else $error("send request not low");
	a_dtr_follows: assert property (
		wc && PWDATA_I[msp_pkg::C_DTR] && !PWDATA_I[msp_pkg::C_DTRREQ]
		|=> !DTR_REQ_N_O) else $error("terminal ready not low");
	a_req_drives: assert property (
		wc && PWDATA_I[msp_pkg::C_REQ] |-> ##[1:2] W_REQ_N_OE)
		else $error("request pin not driven");
	a_sync_dir: assert property (
		$changed(SYNC_N_OE) |-> $past(wm) || $past(wm, 2))
		else $error("sync pin direction moved without mode write");
endmodule // msp_checker

bind msp_port msp_checker msp_checker_i (
	.CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
	.PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O), .IACK_I(IACK_I),
	.W_REQ_N_O(W_REQ_N_O), .W_REQ_N_OE(W_REQ_N_OE), .RTS_N_O(RTS_N_O),
	.DTR_REQ_N_O(DTR_REQ_N_O), .SYNC_N_OE(SYNC_N_OE), .INT_N_OE(INT_N_OE)
);
`default_nettype wire

// >>> tb/msp_line.sv
// Purpose: line and modem equipment beside the serial port
// Assumes: data line wired straight back to our receiver
// Notes:   clock pin runs free, the system clock divided by two
`timescale 1ns/1ns
`default_nettype none
module msp_line (
	input  wire logic       clk_i,
	input  wire logic       txd_i,
	input  wire logic [1:0] on_i,
	output logic            rxd_o,
	output var logic        rclk_o,
	output logic            cts_n_o,
	output logic            dcd_n_o,
	output logic            sync_n_o
);
	// loopback keeps expectations simple; costs no far-end framing
	assign rxd_o = txd_i;
	assign cts_n_o = !on_i[0];
	assign dcd_n_o = !on_i[1];
	// no external sync scenario, so the far end never pulls sync low
	assign sync_n_o = 1'b1;
	initial rclk_o = 1'b0;
	// half the system rate, one bit clock every two cycles
	always @(posedge clk_i) rclk_o <= !rclk_o;
endmodule // msp_line
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking bench for the serial port block
// Assumes: loopback line, APB master in this module
// Notes:   queue model holds bytes in flight
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin \
	fail_count++; $display("FAIL %s exp %0h got %0h", n, e, s); end end
module testbench;
	logic        clk = 1'b0;
	logic        rst = 1'b0;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [7:0]  padr = 8'h00;
	logic [31:0] pwd = 32'h00000000;
	logic        iack = 1'b0;
	logic [1:0]  on = 2'h3;
	logic [31:0] prd;
	logic [31:0] r;
	logic        e;
	logic [7:0]  b;
	logic [7:0]  q[$];
	int          fail_count = 0;
	int          checked = 0;
	int          seed = 28494;
	int          n;
	int          k;
	wire logic rdy, err, txd, rxd, rclk, tco, tcoe, syo, syoe, syp, wqo;
	wire logic wqoe, dtr, rts, cts, dcd, into, intoe;
	wire logic tclk = tcoe ? tco : 1'b1; // pull-up when released
	wire logic syn = syoe ? syo : syp;

	msp_port msp_port_i (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd),
		.PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err), .IACK_I(iack),
		.RXD_I(rxd), .TXD_O(txd), .RX_TX_CLK_N_I(rclk),
		.TX_RX_CLK_N_I(tclk), .TX_RX_CLK_N_O(tco), .TX_RX_CLK_N_OE(tcoe),
		.SYNC_N_I(syn), .SYNC_N_O(syo), .SYNC_N_OE(syoe), .W_REQ_N_O(wqo),
		.W_REQ_N_OE(wqoe), .DTR_REQ_N_O(dtr), .RTS_N_O(rts),
		.CTS_N_I(cts), .CARRIER_DET_N_I(dcd), .INT_N_O(into),
		.INT_N_OE(intoe));
	msp_line msp_line_i (.clk_i(clk), .txd_i(txd), .on_i(on),
		.rxd_o(rxd), .rclk_o(rclk), .cts_n_o(cts), .dcd_n_o(dcd),
		.sync_n_o(syp));

	initial forever #2 clk = ~clk;

	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// one APB transfer; a stalled read waits for data, bounded
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int c;
		c = 0;
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		// look mid-cycle, so ready and data are what the next edge takes
		do begin
			@(negedge clk);
			c++;
		end while (rdy !== 1'b1 && c < 9000);
		if (c >= 9000) begin
			fail_count++;
			close_out();
		end
		r = prd;
		e = err;
		@(posedge clk);
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask

	task automatic send;
		b = 8'($random(seed));
		q.push_back(b);
		apb(1'b1, msp_pkg::A_TXD, {24'h0, b});
	endtask

	task automatic recv;
		logic [7:0] x;
		apb(1'b0, msp_pkg::A_RXD, 32'h0);
		x = q.pop_front();
		`CHK("rx byte", x, r[7:0])
	endtask

	initial begin
		// a real edge on reset, so the design leaves its unknown state
		#1 rst = 1'b1;
		repeat (12) @(posedge clk);
		`CHK("rts idle", 1'b1, rts)
		`CHK("wait mode", 1'b0, wqoe)
		rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, msp_pkg::A_CTRL, 32'h0);
		`CHK("ctrl reset", 32'(msp_pkg::CTRL_RST), r)
		$display("done reset");
		// every combination of the two modem bits
		for (n = 0; n < 4; n++) begin
			apb(1'b1, msp_pkg::A_CTRL, 32'(n));
			@(posedge clk);
			`CHK("dtr pin", !n[0], dtr)
			`CHK("rts pin", !n[1], rts)
		end
		apb(1'b1, msp_pkg::A_MCTL, {29'h0, msp_pkg::CMD_RST_B, 1'b0});
		apb(1'b0, msp_pkg::A_CTRL, 32'h0);
		`CHK("ctrl kept", 32'h3, r)
		apb(1'b0, 8'h22, 32'h0);
		`CHK("unmapped", 1'b1, e)
		$display("done modem bits");
		apb(1'b1, msp_pkg::A_CTRL, 32'h0C);
		for (n = 0; n < 4; n++) begin
			apb(1'b1, msp_pkg::A_MODE, 32'(n << 2));
			`CHK("sync input", 1'b0, syoe)
			send();
			recv();
		end
		// auto enable: send request outlives the bit until tx drains
		apb(1'b1, msp_pkg::A_CTRL, 32'h1E);
		send();
		apb(1'b1, msp_pkg::A_CTRL, 32'h1C);
		@(posedge clk);
		`CHK("rts held", 1'b0, rts)
		recv();
		for (k = 0; k < 3000 && rts !== 1'b1; k++) @(posedge clk);
		`CHK("rts freed", 1'b1, rts)
		on <= 2'h2;
		send();
		repeat (300) @(posedge clk);
		`CHK("tx gated", 1'b1, txd)
		on <= 2'h3;
		recv();
		$display("done async");
		// a rising edge on each modem input sets its flag and the shared interrupt
		apb(1'b1, msp_pkg::A_STAT, 32'h3FF);
		apb(1'b1, msp_pkg::A_MCTL, 32'h1);
		for (n = 0; n < 2; n++) begin
			on[n] <= !on[n];
			repeat (4) @(posedge clk);
			apb(1'b0, msp_pkg::A_STAT, 32'h0);
			`CHK("edge flag", 1'b1, r[6 + n])
			`CHK("irq on", 1'b1, intoe)
			apb(1'b1, msp_pkg::A_STAT, 32'h40 << n);
			@(posedge clk);
			`CHK("irq off", 1'b0, intoe)
		end
		apb(1'b1, msp_pkg::A_CTRL, 32'h40);
		@(posedge clk);
		`CHK("req driven", 1'b1, wqoe)
		`CHK("req ready", 1'b0, wqo)
		apb(1'b1, msp_pkg::A_CTRL, 32'h0);
		iack <= 1'b1;
		@(posedge clk);
		iack <= 1'b0;
		@(posedge clk);
		`CHK("iack wait", 1'b1, wqoe)
		$display("done pins");
		on <= 2'h3;
		apb(1'b1, msp_pkg::A_SYNC, 32'(msp_pkg::SDLC_FLAG));
		// sync match flagged on the pin in internal sync and flag modes
		for (n = 2; n < 4; n++) begin
			apb(1'b1, msp_pkg::A_MODE, 32'(n));
			apb(1'b1, msp_pkg::A_CTRL, 32'h0C);
			apb(1'b1, msp_pkg::A_TXD, 32'(msp_pkg::SDLC_FLAG));
			e = 1'b0;
			for (k = 0; k < 600 && e !== 1'b1; k++) begin
				@(posedge clk);
				e = syoe & !syo;
			end
			`CHK("sync hit", 1'b1, e)
		end
		$display("done sync");
		close_out();
	end
endmodule // testbench
`default_nettype wire
